// *** include/mdsd_pkg.sv ***
package mdsd_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_GEN_BASE = 8'h04;
  localparam logic [7:0] REG_FE_PTR = 8'h08;
  localparam logic [7:0] REG_EXT_PTR = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_SCRATCH = 8'h14;
  localparam logic [7:0] REG_DBG_CNT = 8'h18;

  // Register fields and reset values
  localparam int CTRL_START_BIT = 0;
  localparam int EXT_EN_BIT = 0;
  localparam int PTR_LSB = 5;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Front-end state descriptor fields
  localparam int FE_DWORDS = 3;
  localparam int SCR_BASE_LSB = 10;
  localparam int SCR_SIZE_LSB = 0;
  localparam logic [3:0] SCR_SIZE_MAX = 4'hb;
  localparam int EXT_PRES_BIT = 7;
  localparam int MAXT_LSB = 25;
  localparam int RB_SIZE_LSB = 16;
  localparam int RB_CNT_LSB = 9;
  localparam logic [6:0] RB_CNT_MIN = 7'h01;
  localparam logic [6:0] RB_CNT_MAX = 7'h40;
  localparam int MODE_LSB = 3;
  localparam int CHILD_BIT = 2;
  localparam int DBG_LSB = 0;
  localparam int KD_BASE_LSB = 4;

  // Picture decode state descriptor fields
  localparam int PD_DWORDS = 4;
  localparam int PSTRUCT_LSB = 12;
  localparam int TFF_BIT = 11;
  localparam int SCAN_BIT = 6;
  localparam int PCT_LSB = 9;
  localparam int REMAP_W = 4;

  // Kernel descriptor fields
  localparam int KD_DWORDS = 2;
  localparam logic [31:0] KD_STRIDE = 32'h0000_0010;
  localparam int KSTART_LSB = 6;
  localparam int GRF_LSB = 0;
  localparam int CRLEN_LSB = 26;
  localparam int CROFS_LSB = 20;

  localparam logic [3:0] MODE_GENERIC = 4'h0;
  localparam logic [3:0] MODE_PD = 4'h1;
  localparam logic [3:0] MODE_IS = 4'h2;
  localparam logic [3:0] MODE_MC = 4'h4;
  localparam logic [3:0] MODE_IT = 4'h7;
  localparam logic [3:0] MODE_AIT = 4'hb;

  typedef enum logic [2:0] {
    MDSD_GENERIC, MDSD_PICTURE_DECODE, MDSD_IMAGE_SCALING,
    MDSD_MOTION_COMP_MODE, MDSD_INVERSE_TRANSFORM_MODE,
    MDSD_ALT_INVERSE_TRANSFORM_MODE, MDSD_RESERVED
  } mdsd_mode_t;

  typedef enum logic [1:0] {
    DBG_FREE, DBG_FROZEN, DBG_INIT_ONCE, DBG_INIT_ALWAYS
  } mdsd_dbg_t;

  typedef enum logic [1:0] {
    PS_RESERVED, PS_TOP, PS_BOTTOM, PS_FRAME
  } mdsd_pstruct_t;

  typedef enum logic [1:0] {
    PCT_RESERVED, PCT_INTRA, PCT_PRED, PCT_BIDIR
  } mdsd_pct_t;

  typedef struct packed {
    logic [31:0] scratch_base;
    logic [4:0] scratch_kb;
    logic scratch_size_bad;
    logic [7:0] max_threads;
    logic [9:0] rb_entry_units;
    logic [6:0] rb_entries;
    logic rb_entries_bad;
    mdsd_mode_t mode;
    logic children_present;
    mdsd_dbg_t dbg_ctrl;
    logic [31:0] kd_base;
  } mdsd_fe_cfg_t;

  typedef struct packed {
    mdsd_pstruct_t pstruct;
    logic second_field;
    logic alt_scan;
    mdsd_pct_t coding_type;
  } mdsd_pd_cfg_t;

  typedef struct packed {
    logic [6:0] kernel_idx;
    logic [31:0] kernel_start;
    logic [4:0] grf_blocks;
    logic const_load;
    logic [5:0] const_len;
    logic [5:0] const_ofs;
  } mdsd_kd_t;

endpackage : mdsd_pkg

// *** core/mdsd_remap_mem.sv ***
`timescale 1ns/1ps
`default_nettype none

// Two words of remap entries; read data registered
module mdsd_remap_mem (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic rd_addr,
  output logic [31:0] rd_data
);

  logic [31:0] mem_q [2];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_q[0] <= mdsd_pkg::RST_WORD;
      mem_q[1] <= mdsd_pkg::RST_WORD;
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_data <= mdsd_pkg::RST_WORD;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule : mdsd_remap_mem

`default_nettype wire

// *** core/mdsd_top.sv ***
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module mdsd_top (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  input wire logic obj_valid,
  output logic obj_ready,
  input wire logic [6:0] obj_kernel_idx,
  input wire logic [23:0] obj_id,
  input wire logic root_retire,
  output logic state_valid,
  output mdsd_pkg::mdsd_fe_cfg_t fe_cfg,
  output mdsd_pkg::mdsd_pd_cfg_t pd_cfg,
  output logic kd_valid,
  output mdsd_pkg::mdsd_kd_t kd,
  output logic [23:0] debug_count
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_FE, ST_PD, ST_READY, ST_MAP, ST_KD
  } mdsd_state_t;

  mdsd_state_t state_q;
  logic [31:0] gen_base_q;
  logic [31:0] fe_ptr_q;
  logic [31:0] ext_ptr_q;
  logic ext_en_q;
  logic [31:0] fe_dw_q [mdsd_pkg::FE_DWORDS];
  logic [31:0] pd_dw_q [2];
  logic [31:0] kd_dw0_q;
  logic [1:0] cnt_q;
  logic wait_q;
  logic mem_req_q;
  logic [31:0] mem_addr_q;
  logic [6:0] idx_q;
  logic [6:0] map_idx;
  logic [23:0] obj_id_q;
  logic [7:0] roots_q;
  logic dbg_loaded_q;
  logic start;
  logic accept;
  logic last_dw;
  logic [31:0] fetch_base;
  logic [31:0] remap_rd;
  logic remap_wr;
  logic remap_sel;
  logic [31:0] fe0;
  logic [31:0] fe1;
  logic [31:0] fe2;
  mdsd_pkg::mdsd_fe_cfg_t fe_d;

  assign fe0 = fe_dw_q[0];
  assign fe1 = fe_dw_q[1];
  assign fe2 = fe_dw_q[2];
  assign start = reg_wr && reg_addr == mdsd_pkg::REG_CTRL
    && reg_wdata[mdsd_pkg::CTRL_START_BIT]
    && (state_q == ST_IDLE || state_q == ST_READY);

  // Software-visible pointers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gen_base_q <= mdsd_pkg::RST_WORD;
      fe_ptr_q <= mdsd_pkg::RST_WORD;
      ext_ptr_q <= mdsd_pkg::RST_WORD;
      ext_en_q <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        mdsd_pkg::REG_GEN_BASE: gen_base_q <= reg_wdata;
        mdsd_pkg::REG_FE_PTR: begin
          fe_ptr_q <= {reg_wdata[31:mdsd_pkg::PTR_LSB], 5'h00};
        end
        mdsd_pkg::REG_EXT_PTR: begin
          ext_ptr_q <= {reg_wdata[31:mdsd_pkg::PTR_LSB], 5'h00};
          ext_en_q <= reg_wdata[mdsd_pkg::EXT_EN_BIT];
        end
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= mdsd_pkg::RST_WORD;
    end else if (reg_rd) begin
      case (reg_addr)
        mdsd_pkg::REG_GEN_BASE: reg_rdata <= gen_base_q;
        mdsd_pkg::REG_FE_PTR: reg_rdata <= fe_ptr_q;
        mdsd_pkg::REG_EXT_PTR: reg_rdata <= {ext_ptr_q[31:1], ext_en_q};
        mdsd_pkg::REG_STATUS: begin
          reg_rdata <= {16'h0000, roots_q, 1'b0, 3'(fe_cfg.mode),
            2'b00, state_valid, state_q != ST_IDLE
            && state_q != ST_READY};
        end
        mdsd_pkg::REG_SCRATCH: reg_rdata <= fe_cfg.scratch_base;
        mdsd_pkg::REG_DBG_CNT: reg_rdata <= {8'h00, debug_count};
        default: reg_rdata <= mdsd_pkg::RST_WORD;
      endcase
    end else begin
      reg_rdata <= mdsd_pkg::RST_WORD;
    end
  end

  // Descriptor fetch: one outstanding read of consecutive dwords
  always_comb begin
    case (state_q)
      ST_FE: fetch_base = gen_base_q + fe_ptr_q;
      ST_PD: fetch_base = gen_base_q + ext_ptr_q;
      default: fetch_base = fe_cfg.kd_base + 32'(idx_q) * mdsd_pkg::KD_STRIDE;
    endcase
  end

  always_comb begin
    case (state_q)
      ST_FE: last_dw = cnt_q == 2'(mdsd_pkg::FE_DWORDS - 1);
      ST_PD: last_dw = cnt_q == 2'(mdsd_pkg::PD_DWORDS - 1);
      default: last_dw = cnt_q == 2'(mdsd_pkg::KD_DWORDS - 1);
    endcase
  end

  assign obj_ready = state_q == ST_READY && roots_q < fe_cfg.max_threads;
  assign accept = obj_valid && obj_ready;
  assign mem_req = mem_req_q;
  assign mem_addr = mem_addr_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= ST_IDLE;
      cnt_q <= 2'b00;
      wait_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_addr_q <= mdsd_pkg::RST_WORD;
      state_valid <= 1'b0;
      idx_q <= 7'h00;
      obj_id_q <= 24'h000000;
    end else begin
      mem_req_q <= 1'b0;
      case (state_q)
        ST_IDLE, ST_READY: begin
          if (start) begin
            state_q <= ST_FE;
            state_valid <= 1'b0;
            cnt_q <= 2'b00;
          end else if (accept) begin
            idx_q <= obj_kernel_idx;
            obj_id_q <= obj_id;
            state_q <= ST_MAP;
          end
        end
        ST_FE, ST_PD, ST_KD: begin
          if (!wait_q) begin
            wait_q <= 1'b1;
            mem_req_q <= 1'b1;
            mem_addr_q <= fetch_base + {28'h0000000, cnt_q, 2'b00};
          end else if (mem_rvalid) begin
            wait_q <= 1'b0;
            cnt_q <= cnt_q + 2'b01;
            if (last_dw) begin
              cnt_q <= 2'b00;
              if (state_q == ST_FE && ext_en_q && fe_d.mode == mdsd_pkg::MDSD_PICTURE_DECODE) begin
                state_q <= ST_PD;
              end else begin
                state_q <= ST_READY;
                state_valid <= 1'b1;
              end
            end
          end
        end
        ST_MAP: begin
          idx_q <= map_idx;
          state_q <= ST_KD;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Capture fetched dwords
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < mdsd_pkg::FE_DWORDS; i++) begin
        fe_dw_q[i] <= mdsd_pkg::RST_WORD;
      end
      pd_dw_q[0] <= mdsd_pkg::RST_WORD;
      pd_dw_q[1] <= mdsd_pkg::RST_WORD;
      kd_dw0_q <= mdsd_pkg::RST_WORD;
    end else if (wait_q && mem_rvalid) begin
      if (state_q == ST_FE) begin
        fe_dw_q[cnt_q] <= mem_rdata;
      end else if (state_q == ST_PD && !cnt_q[1]) begin
        pd_dw_q[cnt_q[0]] <= mem_rdata;
      end else if (state_q == ST_KD && cnt_q == 2'b00) begin
        kd_dw0_q <= mem_rdata;
      end
    end
  end

  // Remap dwords two and three go to the table memory
  assign remap_wr = state_q == ST_PD && wait_q && mem_rvalid && cnt_q[1];
  // The index register loads on the acceptance edge, after this read is issued, so address from the input
  assign remap_sel = accept ? obj_kernel_idx[3] : idx_q[3];

  mdsd_remap_mem u_remap (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr_en(remap_wr),
    .wr_addr(cnt_q[0]),
    .wr_data(mem_rdata),
    .rd_addr(remap_sel),
    .rd_data(remap_rd)
  );

  // Read issued on acceptance, so the word is ready in the map cycle
  always_comb begin
    map_idx = idx_q;
    if (fe_cfg.mode == mdsd_pkg::MDSD_PICTURE_DECODE && idx_q[6:4] == 3'b000) begin
      if (!idx_q[3]) begin
        map_idx = {3'b000, remap_rd[idx_q[2:0]*mdsd_pkg::REMAP_W +: mdsd_pkg::REMAP_W]};
      end else if (pd_cfg.pstruct == mdsd_pkg::PS_FRAME) begin
        map_idx = {3'b000, remap_rd[idx_q[2:0]*mdsd_pkg::REMAP_W +: mdsd_pkg::REMAP_W]};
      end
    end
  end

  // Front-end decode
  always_comb begin
    fe_d.scratch_base = gen_base_q + {fe0[31:mdsd_pkg::SCR_BASE_LSB], 10'h000};
    fe_d.scratch_kb = 5'(fe0[mdsd_pkg::SCR_SIZE_LSB +: 4]) + 5'h01;
    fe_d.scratch_size_bad = fe0[mdsd_pkg::SCR_SIZE_LSB +: 4] > mdsd_pkg::SCR_SIZE_MAX;
    fe_d.max_threads = 8'(fe1[mdsd_pkg::MAXT_LSB +: 7]) + 8'h01;
    fe_d.rb_entry_units = 10'(fe1[mdsd_pkg::RB_SIZE_LSB +: 9]) + 10'h001;
    fe_d.rb_entries = fe1[mdsd_pkg::RB_CNT_LSB +: 7];
    fe_d.rb_entries_bad = fe_d.rb_entries < mdsd_pkg::RB_CNT_MIN
      || fe_d.rb_entries > mdsd_pkg::RB_CNT_MAX;
    case (fe1[mdsd_pkg::MODE_LSB +: 4])
      mdsd_pkg::MODE_GENERIC: fe_d.mode = mdsd_pkg::MDSD_GENERIC;
      mdsd_pkg::MODE_PD: fe_d.mode = mdsd_pkg::MDSD_PICTURE_DECODE;
      mdsd_pkg::MODE_IS: fe_d.mode = mdsd_pkg::MDSD_IMAGE_SCALING;
      mdsd_pkg::MODE_MC: fe_d.mode = mdsd_pkg::MDSD_MOTION_COMP_MODE;
      mdsd_pkg::MODE_IT: fe_d.mode = mdsd_pkg::MDSD_INVERSE_TRANSFORM_MODE;
      mdsd_pkg::MODE_AIT: fe_d.mode = mdsd_pkg::MDSD_ALT_INVERSE_TRANSFORM_MODE;
      default: fe_d.mode = mdsd_pkg::MDSD_RESERVED;
    endcase
    // Children present is passed as programmed; software keeps it low in
    // picture-decode mode
    fe_d.children_present = fe1[mdsd_pkg::CHILD_BIT];
    fe_d.dbg_ctrl = mdsd_pkg::mdsd_dbg_t'(fe1[mdsd_pkg::DBG_LSB +: 2]);
    fe_d.kd_base = gen_base_q + {fe2[31:mdsd_pkg::KD_BASE_LSB], 4'h0};
  end

  assign fe_cfg = fe_d;

  // Picture decode fields
  always_comb begin
    pd_cfg.pstruct = mdsd_pkg::mdsd_pstruct_t'(pd_dw_q[0][mdsd_pkg::PSTRUCT_LSB +: 2]);
    pd_cfg.second_field = (pd_cfg.pstruct == mdsd_pkg::PS_TOP && !pd_dw_q[0][mdsd_pkg::TFF_BIT])
      || (pd_cfg.pstruct == mdsd_pkg::PS_BOTTOM && pd_dw_q[0][mdsd_pkg::TFF_BIT]);
    pd_cfg.alt_scan = pd_dw_q[0][mdsd_pkg::SCAN_BIT];
    pd_cfg.coding_type = mdsd_pkg::mdsd_pct_t'(pd_dw_q[1][mdsd_pkg::PCT_LSB +: 2]);
  end

  // Kernel descriptor output, one pulse per object
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      kd_valid <= 1'b0;
      kd <= '0;
    end else begin
      kd_valid <= state_q == ST_KD && wait_q && mem_rvalid && last_dw;
      if (state_q == ST_KD && wait_q && mem_rvalid && last_dw) begin
        kd.kernel_idx <= idx_q;
        kd.kernel_start <= gen_base_q + {kd_dw0_q[31:mdsd_pkg::KSTART_LSB], 6'h00};
        kd.grf_blocks <= 5'(kd_dw0_q[mdsd_pkg::GRF_LSB +: 4]) + 5'h01;
        kd.const_load <= mem_rdata[mdsd_pkg::CRLEN_LSB +: 6] != 6'h00;
        kd.const_len <= mem_rdata[mdsd_pkg::CRLEN_LSB +: 6];
        // Offset is meaningless without a length, so it is forced to zero
        kd.const_ofs <= (mem_rdata[mdsd_pkg::CRLEN_LSB +: 6] == 6'h00) ? 6'h00
          : mem_rdata[mdsd_pkg::CROFS_LSB +: 6];
      end
    end
  end

  // Active root count; accept and retire together leave it unchanged
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      roots_q <= 8'h00;
    end else if (accept && !root_retire) begin
      roots_q <= roots_q + 8'h01;
    end else if (!accept && root_retire && roots_q != 8'h00) begin
      roots_q <= roots_q - 8'h01;
    end
  end

  // Debug counter
  always_ff @(posedge clk_sys) begin
    if (srst || start) begin
      debug_count <= 24'h000000;
      dbg_loaded_q <= 1'b0;
    end else begin
      case (fe_cfg.dbg_ctrl)
        mdsd_pkg::DBG_FREE: debug_count <= debug_count + 24'h000001;
        mdsd_pkg::DBG_FROZEN: ;
        mdsd_pkg::DBG_INIT_ONCE: begin
          if (accept && !dbg_loaded_q) begin
            debug_count <= obj_id;
            dbg_loaded_q <= 1'b1;
          end else begin
            debug_count <= debug_count + 24'h000001;
          end
        end
        default: begin
          debug_count <= accept ? obj_id : debug_count + 24'h000001;
        end
      endcase
    end
  end

endmodule : mdsd_top

`default_nettype wire

// *** testbench/mdsd_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Descriptor memory; one read in flight, answered after lat extra cycles
module mdsd_mem_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] lat,
  input wire logic ld_en,
  input wire logic [6:0] ld_addr,
  input wire logic [31:0] ld_data,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem_q [128];
  logic [31:0] word_q;
  logic [3:0] cnt_q;
  logic busy_q;
  always_ff @(posedge clk_sys) begin
    if (ld_en) mem_q[ld_addr] <= ld_data;
  end
  always_ff @(posedge clk_sys) begin
    mem_rvalid <= 1'b0;
    // Data only means something with the valid pulse
    mem_rdata <= ~mem_rdata;
    if (srst) begin
      busy_q <= 1'b0;
      mem_rdata <= 32'h0;
    end else if (mem_req) begin
      busy_q <= 1'b1;
      cnt_q <= lat;
      word_q <= mem_q[mem_addr[8:2]];
    end else if (busy_q && cnt_q == 4'h0) begin
      busy_q <= 1'b0;
      mem_rvalid <= 1'b1;
      mem_rdata <= word_q;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule : mdsd_mem_model

`default_nettype wire

// *** testbench/mdsd_top_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module mdsd_top_monitor (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic mem_req,
  input wire logic obj_valid,
  input wire logic obj_ready,
  input wire logic [23:0] obj_id,
  input wire logic root_retire,
  input wire logic state_valid,
  input wire mdsd_pkg::mdsd_fe_cfg_t fe_cfg,
  input wire logic kd_valid,
  input wire mdsd_pkg::mdsd_kd_t kd,
  input wire logic [23:0] debug_count
);
  logic acc;
  logic run;
  logic [8:0] roots_q;
  assign acc = obj_valid && obj_ready;
  // Start clears the counter, so the free and frozen counter checks skip that edge
  assign run = state_valid && !(reg_wr && reg_addr == mdsd_pkg::REG_CTRL);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      roots_q <= 9'h0;
    end else if (acc != root_retire) begin
      roots_q <= acc ? roots_q + 9'h1 : roots_q - 9'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  AST_ROOT_LIMIT: assert property (
    obj_ready |-> roots_q < {1'b0, fe_cfg.max_threads}) else $error("roots");
  AST_READY_LATCHED: assert property (
    obj_ready |-> state_valid) else $error("ready early");
  AST_REQ_PULSE: assert property (
    mem_req |=> !mem_req) else $error("request too long");
  AST_KD_ANSWER: assert property (
    acc |-> ##[3:80] kd_valid) else $error("no descriptor");
  AST_SCRATCH_FLAG: assert property (
    fe_cfg.scratch_size_bad == (fe_cfg.scratch_kb > 5'hc))
    else $error("scratch flag");
  AST_RB_FLAG: assert property (
    fe_cfg.rb_entries_bad == !(fe_cfg.rb_entries inside {[7'h1:7'h40]}))
    else $error("entry flag");
  AST_CONST_NONE: assert property (
    kd_valid && kd.const_len == 6'h0 |-> !kd.const_load
    && kd.const_ofs == 6'h0) else $error("const load");
  AST_GRF_RANGE: assert property (
    kd_valid |-> kd.grf_blocks inside {[5'h1:5'h10]}) else $error("grf");
  AST_DBG_FROZEN: assert property (
    run && fe_cfg.dbg_ctrl == mdsd_pkg::DBG_FROZEN |=> $stable(debug_count))
    else $error("counter moved");
  AST_DBG_FREE: assert property (
    run && fe_cfg.dbg_ctrl == mdsd_pkg::DBG_FREE
    |=> debug_count == $past(debug_count) + 24'h1) else $error("counter");
  AST_DBG_ALWAYS: assert property (
    acc && fe_cfg.dbg_ctrl == mdsd_pkg::DBG_INIT_ALWAYS
    |=> debug_count == $past(obj_id)) else $error("counter load");
endmodule : mdsd_top_monitor

bind mdsd_top mdsd_top_monitor u_mon (.clk_sys(clk_sys), .srst(srst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .mem_req(mem_req),
  .obj_valid(obj_valid), .obj_ready(obj_ready), .obj_id(obj_id),
  .root_retire(root_retire), .state_valid(state_valid), .fe_cfg(fe_cfg),
  .kd_valid(kd_valid), .kd(kd), .debug_count(debug_count));

`default_nettype wire

// *** testbench/mdsd_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module mdsd_top_tb;
  // The one unsupported code, 4'h3, appears only to prove the mode decode
  localparam logic [3:0] MODES [9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h7,
    4'hb, 4'h3, 4'h1, 4'h1};
  logic clk_sys = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic obj_valid = 1'b0, root_retire = 1'b0, ld_en = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, ld_data = 32'h0;
  logic [6:0] obj_kernel_idx = 7'h0, ld_addr = 7'h0;
  logic [23:0] obj_id = 24'h0;
  logic [3:0] lat = 4'h0;
  logic mem_req, mem_rvalid, obj_ready, state_valid, kd_valid;
  logic [31:0] reg_rdata, mem_addr, mem_rdata, gb;
  logic [23:0] debug_count;
  mdsd_pkg::mdsd_fe_cfg_t fe_cfg;
  mdsd_pkg::mdsd_pd_cfg_t pd_cfg;
  mdsd_pkg::mdsd_kd_t kd;
  logic [31:0] img [128];
  logic [31:0] aq [$];
  int err_total = 0;
  int check_count = 0;

  mdsd_top uut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .obj_valid(obj_valid),
    .obj_ready(obj_ready), .obj_kernel_idx(obj_kernel_idx), .obj_id(obj_id),
    .root_retire(root_retire), .state_valid(state_valid), .fe_cfg(fe_cfg),
    .pd_cfg(pd_cfg), .kd_valid(kd_valid), .kd(kd),
    .debug_count(debug_count));
  mdsd_mem_model mem (.clk_sys(clk_sys), .srst(srst), .mem_req(mem_req),
    .mem_addr(mem_addr), .lat(lat), .ld_en(ld_en), .ld_addr(ld_addr),
    .ld_data(ld_data), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (mem_req === 1'b1) aq.push_back(mem_addr - gb);
  end

  task automatic finish_test();
    $display("mismatches %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(128'(reg_rdata), 128'(e));
  endtask : rd

  function automatic mdsd_pkg::mdsd_mode_t mode_of(input logic [3:0] m);
    case (m)
      4'h0: return mdsd_pkg::MDSD_GENERIC;
      4'h1: return mdsd_pkg::MDSD_PICTURE_DECODE;
      4'h2: return mdsd_pkg::MDSD_IMAGE_SCALING;
      4'h4: return mdsd_pkg::MDSD_MOTION_COMP_MODE;
      4'h7: return mdsd_pkg::MDSD_INVERSE_TRANSFORM_MODE;
      4'hb: return mdsd_pkg::MDSD_ALT_INVERSE_TRANSFORM_MODE;
      default: return mdsd_pkg::MDSD_RESERVED;
    endcase
  endfunction : mode_of

  function automatic mdsd_pkg::mdsd_fe_cfg_t exp_fe(input logic [31:0] d0,
      input logic [31:0] d1, input logic [31:0] d2, input logic [31:0] b);
    mdsd_pkg::mdsd_fe_cfg_t f;
    f.scratch_base = b + {d0[31:10], 10'h0};
    f.scratch_kb = {1'b0, d0[3:0]} + 5'h1;
    f.scratch_size_bad = d0[3:0] > 4'hb;
    f.max_threads = {1'b0, d1[31:25]} + 8'h1;
    f.rb_entry_units = {1'b0, d1[24:16]} + 10'h1;
    f.rb_entries = d1[15:9];
    f.rb_entries_bad = d1[15:9] == 7'h0 || d1[15:9] > 7'h40;
    f.mode = mode_of(d1[6:3]);
    f.children_present = d1[2];
    f.dbg_ctrl = mdsd_pkg::mdsd_dbg_t'(d1[1:0]);
    f.kd_base = b + {d2[31:4], 4'h0};
    return f;
  endfunction : exp_fe

  function automatic logic [6:0] map_idx(input logic [6:0] x,
      input logic [31:0] p0, input logic [63:0] t, input logic pdm);
    if (pdm && x < 7'h8) return {3'h0, t[4 * x +: 4]};
    if (pdm && x < 7'h10 && p0[13:12] == 2'h3)
      return {3'h0, t[4 * x +: 4]};
    return x;
  endfunction : map_idx

  function automatic mdsd_pkg::mdsd_kd_t exp_kd(input logic [6:0] m);
    mdsd_pkg::mdsd_kd_t k;
    logic [31:0] w0, w1;
    w0 = img[32 + 4 * m];
    w1 = img[33 + 4 * m];
    k.kernel_idx = m;
    k.kernel_start = gb + {w0[31:6], 6'h0};
    k.grf_blocks = {1'b0, w0[3:0]} + 5'h1;
    k.const_len = w1[31:26];
    k.const_load = |w1[31:26];
    k.const_ofs = k.const_load ? w1[25:20] : 6'h0;
    return k;
  endfunction : exp_kd

  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end

  initial begin
    logic [31:0] d0, d1, p0, p1;
    logic [63:0] t;
    logic [6:0] ix, mx;
    logic pdm, ext;
    int n;
    void'($urandom(47));
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    gb = 32'h0;
    @(negedge clk_sys);
    chk(128'(fe_cfg), 128'(exp_fe(32'h0, 32'h0, 32'h0, 32'h0)));
    rd(8'h1c, 32'h0);
    rd(mdsd_pkg::REG_CTRL, 32'h0);
    for (int i = 0; i < 9; i++) begin
      pdm = MODES[i] == 4'h1;
      ext = pdm | i[0];
      gb = $urandom & 32'hffff_fe00;
      lat = 4'($urandom % 4);
      // Clear bits 0, 4 and 5 so every kernel register count is legal
      foreach (img[w]) img[w] = $urandom & 32'hffff_ffce;
      d0 = ($urandom & 32'hffff_fc0f) | {24'h0, ext, 7'h0};
      d1 = {7'($urandom % 2), 9'($urandom), 7'($urandom), 2'h0, MODES[i],
        ~pdm & 1'($urandom), pdm ? 2'($urandom % 3) : 2'($urandom)};
      p0 = ($urandom & 32'hffff_cfff)
        | {18'h0, 2'(i == 1 ? 1 : i == 7 ? 2 : 3), 12'h0};
      p1 = i == 8 ? $urandom : ($urandom & 32'hffff_f9ff) | 32'h400;
      t = {img[19], img[18]};
      {img[8], img[9], img[10], img[16], img[17]} = {d0, d1, 32'h80, p0, p1};
      foreach (img[w]) begin
        @(posedge clk_sys);
        ld_en <= 1'b1;
        ld_addr <= 7'(w);
        ld_data <= img[w];
      end
      @(posedge clk_sys);
      ld_en <= 1'b0;
      wr(mdsd_pkg::REG_GEN_BASE, gb);
      wr(mdsd_pkg::REG_FE_PTR, 32'h3f);
      wr(mdsd_pkg::REG_EXT_PTR, {27'h2, 4'hf, ext});
      rd(mdsd_pkg::REG_FE_PTR, 32'h20);
      rd(mdsd_pkg::REG_EXT_PTR, {27'h2, 4'h0, ext});
      aq.delete();
      wr(mdsd_pkg::REG_CTRL, 32'h1);
      repeat (2) @(negedge clk_sys);
      for (n = 0; n < 300 && state_valid !== 1'b1; n++) @(negedge clk_sys);
      chk(128'(state_valid), 128'(1'b1));
      n = pdm ? 7 : 3;
      chk(128'(aq.size()), 128'(n));
      for (int k = 0; k < n && k < aq.size(); k++)
        chk(128'(aq[k]), 128'(32'(k < 3 ? 32 + 4 * k : 52 + 4 * k)));
      chk(128'(fe_cfg), 128'(exp_fe(d0, d1, 32'h80, gb)));
      rd(mdsd_pkg::REG_SCRATCH, gb + {d0[31:10], 10'h0});
      rd(mdsd_pkg::REG_STATUS, {24'h0, 1'b0, 3'(mode_of(d1[6:3])), 4'h2});
      if (pdm) begin
        chk(128'({pd_cfg.pstruct, pd_cfg.alt_scan, pd_cfg.coding_type}),
          128'({p0[13:12], p0[6], p1[10:9]}));
        if (p0[13:12] != 2'h3 && p1[10:9] == 2'h2)
          chk(128'(pd_cfg.second_field), 128'(p0[11] ^ p0[12]));
      end
      mx = d1[31:25] + 7'h1;
      for (int k = 0; k < mx; k++) begin
        ix = k == 0 ? 7'(i + 7) : 7'($urandom % 20);
        @(posedge clk_sys);
        obj_valid <= 1'b1;
        obj_kernel_idx <= ix;
        obj_id <= 24'($urandom);
        n = 0;
        do @(negedge clk_sys); while (obj_ready !== 1'b1 && n++ < 50);
        @(posedge clk_sys);
        obj_valid <= 1'b0;
        n = 0;
        do @(negedge clk_sys); while (kd_valid !== 1'b1 && n++ < 100);
        chk(128'(kd_valid), 128'(1'b1));
        chk(128'(kd), 128'(exp_kd(map_idx(ix, p0, t, pdm))));
      end
      repeat (2) @(negedge clk_sys);
      chk(128'(obj_ready), 128'(1'b0));
      repeat (mx) begin
        @(posedge clk_sys);
        root_retire <= 1'b1;
        @(posedge clk_sys);
        root_retire <= 1'b0;
      end
      @(negedge clk_sys);
      chk(128'(obj_ready), 128'(1'b1));
    end
    finish_test();
  end
endmodule : mdsd_top_tb

`default_nettype wire
